// ===== include/tcp_pkg.sv
// constants, modes and register indices for the 16-bit compare/pwm timer
// assumes 8-bit registers placed one per 32-bit word, byte address = 4 * index
package tcp_pkg;
  localparam int unsigned IDX_W = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CC0L = 8'hDA;
  localparam logic [7:0] IDX_CC0H = 8'hDB;
  localparam logic [7:0] IDX_CC1L = 8'hDC;
  localparam logic [7:0] IDX_CC1H = 8'hDD;
  localparam logic [7:0] IDX_CC2L = 8'hDE;
  localparam logic [7:0] IDX_CC2H = 8'hDF;
  localparam logic [7:0] IDX_CNTL = 8'hE2;
  localparam logic [7:0] IDX_CNTH = 8'hE3;
  localparam logic [7:0] IDX_CTL = 8'hE4;
  localparam logic [7:0] IDX_CCTL0 = 8'hE5;
  localparam logic [7:0] IDX_CCTL2 = 8'hE7;
  localparam logic [7:0] IDX_OVFM = 8'hE8;
  localparam logic [7:0] IDX_CC_STEP = 8'h02;
  // control/status field positions
  localparam int unsigned CTL_OVF_BIT = 4;
  localparam int unsigned CTL_DIV_LSB = 2;
  localparam int unsigned CTL_MODE_LSB = 0;
  // channel control field positions
  localparam int unsigned CCTL_IM_BIT = 6;
  localparam int unsigned CCTL_CMP_LSB = 3;
  localparam int unsigned CCTL_EN_BIT = 2;
  localparam logic [7:0] CCTL_WMASK = 8'h7F;
  // reset values
  localparam logic [7:0] CCTL_RST = 8'h40;
  localparam logic [3:0] CTL_CFG_RST = 4'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic OVFM_RST = 1'b1;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // prescaler last-count values for /1, /8, /32, /128
  localparam logic [6:0] PRE_LAST_1 = 7'h00;
  localparam logic [6:0] PRE_LAST_8 = 7'h07;
  localparam logic [6:0] PRE_LAST_32 = 7'h1F;
  localparam logic [6:0] PRE_LAST_128 = 7'h7F;
  localparam logic [6:0] PRE_ONE = 7'h01;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TCP_SUSPEND = 2'b00,
    TCP_FREE = 2'b01,
    TCP_MODULO = 2'b10,
    TCP_UPDOWN = 2'b11
  } tcp_mode_t;
  typedef enum logic [2:0] {
    CMP_SET = 3'b000,
    CMP_CLR = 3'b001,
    CMP_TOG = 3'b010,
    CMP_SET_UP = 3'b011,
    CMP_CLR_UP = 3'b100,
    CMP_CLR0_SET = 3'b101,
    CMP_SET0_CLR = 3'b110,
    CMP_NONE = 3'b111
  } tcp_cmp_t;
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } tcp_rd_t;
endpackage

// ===== src/tcp_prescaler.sv
// prescaler: turns global tick pulses into counter update strobes
// assumes global_tick is a one-cycle pulse synchronous to aclk
`timescale 1ns/1ps
module tcp_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic global_tick,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic step
);
  import tcp_pkg::*;
  logic [6:0] pre_r;
  logic [6:0] pre_nxt;
  wire logic [6:0] last;
  wire logic wrap;
  // division select, one last-count per code
  assign last = (div_sel == 2'b00) ? PRE_LAST_1 :
                (div_sel == 2'b01) ? PRE_LAST_8 :
                (div_sel == 2'b10) ? PRE_LAST_32 : PRE_LAST_128;
  assign wrap = (pre_r >= last);
  // only qualified ticks move the counter
  assign step = run & global_tick & wrap;
  assign pre_nxt = !run ? PRE_LAST_1 :
                   !global_tick ? pre_r :
                   wrap ? PRE_LAST_1 : pre_r + PRE_ONE;
  // restart from zero while suspended, so a start gives a full first period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= PRE_LAST_1;
    end else begin
      pre_r <= pre_nxt;
    end
  end
endmodule

// ===== src/tcp_channel.sv
// one compare channel: buffered compare value, match detect, output pin
// assumes cnt_nxt/adv come from the counter in the same cycle it updates
`timescale 1ns/1ps
module tcp_channel #(
  parameter bit IS_CH0 = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic adv,
  input wire logic [15:0] cnt_nxt,
  input wire logic moving_down,
  input wire logic updown,
  input wire logic ch0_match,
  input wire logic en,
  input wire logic [2:0] cmp_mode,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wbyte,
  output logic match,
  output logic pin,
  output logic [15:0] value
);
  import tcp_pkg::*;
  logic [7:0] low_buf_r;
  logic [15:0] val_r;
  logic [15:0] pend_r;
  logic pend_v_r;
  logic pin_r;
  wire logic at_zero;
  wire logic direct;
  wire logic pin_nxt;
  wire logic do_set;
  wire logic do_clr;
  wire logic do_tog;
  wire logic up_hit;
  wire logic dn_hit;
  // modes 1-3 load at once, all others wait for the counter to reach zero
  assign direct = (cmp_mode == CMP_SET) | (cmp_mode == CMP_CLR) | (cmp_mode == CMP_TOG);
  assign at_zero = adv & (cnt_nxt == CNT_ZERO);
  assign match = adv & en & (cnt_nxt == val_r);
  assign up_hit = match & !moving_down;
  assign dn_hit = match & moving_down;
  // pin actions per compare code; channel 0 has no period-relative codes
  assign do_set = (match & (cmp_mode == CMP_SET)) |
                  (up_hit & (cmp_mode == CMP_SET_UP)) |
                  (en & (cmp_mode == CMP_CLR_UP) & (updown ? dn_hit : at_zero)) |
                  (!IS_CH0 & match & (cmp_mode == CMP_CLR0_SET)) |
                  (!IS_CH0 & en & adv & ch0_match & (cmp_mode == CMP_SET0_CLR));
  assign do_clr = (match & (cmp_mode == CMP_CLR)) |
                  (up_hit & (cmp_mode == CMP_CLR_UP)) |
                  (en & (cmp_mode == CMP_SET_UP) & (updown ? dn_hit : at_zero)) |
                  (!IS_CH0 & en & adv & ch0_match & (cmp_mode == CMP_CLR0_SET)) |
                  (!IS_CH0 & match & (cmp_mode == CMP_SET0_CLR));
  assign do_tog = match & (cmp_mode == CMP_TOG);
  // a set and a clear in the same cycle leave the pin set, whichever is the own match
  assign pin_nxt = do_tog ? !pin_r : (do_set & !do_clr) ? 1'b1 :
                   (do_clr & !do_set) ? 1'b0 : (do_set & do_clr) ? match : pin_r;
  assign pin = pin_r; // flop output keeps the edge glitch-free
  assign value = val_r;
  // low byte waits in a buffer until the high byte arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_buf_r <= BYTE_ZERO;
      val_r <= CNT_ZERO;
      pend_r <= CNT_ZERO;
      pend_v_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      if (wr_low) begin
        low_buf_r <= wbyte;
      end
      if (wr_high && direct) begin
        val_r <= {wbyte, low_buf_r};
        pend_v_r <= 1'b0;
      end else if (wr_high) begin
        pend_r <= {wbyte, low_buf_r};
        pend_v_r <= 1'b1;
      end else if (pend_v_r && (at_zero || direct)) begin
        val_r <= pend_r;
        pend_v_r <= 1'b0;
      end
    end
  end
endmodule

// ===== src/tcp_timer.sv
// top of the 16-bit three-channel compare/pwm timer with an axi4-lite slave
// assumes global_tick is the divided system tick, one-cycle pulse on aclk
// Notes on behaviour
// - a channel in compare mode drives its pin as an output.
// - on equality the pin is set, cleared or toggled per compare code.
// - pin edges come from flops, so no glitches within a mode.
// - compare low byte write is buffered until the high byte is written.
// - codes for modes 1 to 3 load the new value at once.
// - other codes load the new value when the counter reaches zero.
// - channel 0 lacks the period-relative codes used by modes 6 and 7.
// - each match sets the channel flag, except channel 0 in up/down counting; its mask gates the request.
// - in up/down counting the channel 0 flag is set at zero.
// - overflow and channel events all feed one request line.
// - a request stays until software clears the flag; masked sources never request.
// - setting a mask with its flag already set raises the request at once.
// - three dma triggers pulse on channel 0, 1 and 2 compare events.
// - count high byte reads the upper byte latched at the low byte read.
// - any count low byte write clears the whole counter, value ignored.
// - flags at bits 7..4 of control; write 0 clears, 1 does nothing.
// - overflow flag sets at terminal count in free and modulo counting.
// - prescaler code 00/01/10/11 divides the tick by 1, 8, 32, 128.
// - mode 00 halts, 01 free runs, 10 modulo, 11 counts up and down.
// - up/down period is twice the channel 0 value in timer ticks.
// - codes 000 set, 001 clear, 010 toggle, 011 and 100 set/clear pairs.
// - channels 1 and 2: 101 clears on ch0 match, sets on own; 110 reverse.
// - channel interrupt masks reset to one.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module tcp_timer #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic global_tick,
  output logic [2:0] ch_out,
  output logic [2:0] ch_oe,
  output logic dma_trigger_channel0,
  output logic dma_trigger_channel1,
  output logic dma_trigger_channel2,
  output logic irq_req
);
  import tcp_pkg::*;

  // refuse an address bus too narrow for the highest index
  generate
    if (ADDR_W < IDX_W + 2) begin : g_bad_addr
      $error("tcp_timer: ADDR_W too small for register indices");
    end
  endgenerate

  // write channel holding registers
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // read channel
  tcp_rd_t rd_state_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // timer state
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic dir_down_r;
  logic dir_down_nxt;
  logic moving_down;
  logic [7:0] cnt_hi_hold_r;
  logic [3:0] ctl_cfg_r;
  logic [3:0] flag_r;
  logic [3:0] flag_nxt;
  logic ovf_mask_r;
  logic [7:0] cctl_r [3];
  logic [2:0] dma_r;
  logic step;

  // per-channel wires
  wire logic [2:0] ch_match;
  wire logic [2:0] ch_pin;
  wire logic [15:0] ch_val [3];
  wire logic [2:0] ch_en;
  wire logic [2:0] ch_im;
  wire logic [2:0] ch_wr_low;
  wire logic [2:0] ch_wr_high;
  wire logic [2:0] ch_wr_cctl;

  // address decode for the committed write and the accepted read
  wire logic wr_fire;
  wire logic wr_en8;
  wire logic [IDX_W-1:0] wr_idx;
  wire logic wr_upper_ok;
  wire logic wr_mapped;
  wire logic rd_fire;
  wire logic [IDX_W-1:0] rd_idx;
  wire logic rd_upper_ok;
  wire logic rd_mapped;
  wire logic [7:0] rd_byte;
  wire logic wr_cntl;
  wire logic wr_ctl;
  wire logic wr_ovfm;
  wire logic rd_cntl;

  // mode decode
  wire tcp_mode_t mode;
  wire logic run;
  wire logic adv;
  wire logic updown;
  wire logic [15:0] cc0;
  wire logic ovf_evt;
  wire logic at_zero;
  wire logic [3:0] flag_set;
  wire logic [3:0] flag_clr;

  // index is the byte address over four; upper bits must be zero to hit
  assign wr_idx = awaddr_r[IDX_W+1:2];
  assign rd_idx = s_axi_araddr[IDX_W+1:2];
  assign wr_upper_ok = ((awaddr_r >> (IDX_W + 2)) == '0);
  assign rd_upper_ok = ((s_axi_araddr >> (IDX_W + 2)) == '0);
  assign wr_mapped = wr_upper_ok & tcp_hit(wr_idx);
  assign rd_mapped = rd_upper_ok & tcp_hit(rd_idx);

  // every implemented index, used for the slverr answer
  function automatic logic tcp_hit(input logic [IDX_W-1:0] idx);
    tcp_hit = ((idx >= IDX_CC0L) && (idx <= IDX_CC2H)) ||
              ((idx >= IDX_CNTL) && (idx <= IDX_OVFM));
  endfunction

  // write commits once address and data are both held; either may come first
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  // registers live in byte lane 0; a write without that strobe changes nothing
  assign wr_en8 = wr_fire && wstrb0_r && wr_mapped;
  assign wr_cntl = wr_en8 && (wr_idx == IDX_CNTL);
  assign wr_ctl = wr_en8 && (wr_idx == IDX_CTL);
  assign wr_ovfm = wr_en8 && (wr_idx == IDX_OVFM);
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wbyte_r <= BYTE_ZERO;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read: one outstanding, data registered the edge the address is taken
  assign s_axi_arready = (rd_state_r == RD_IDLE);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_cntl = rd_fire && rd_mapped && (rd_idx == IDX_CNTL);
  assign s_axi_rvalid = (rd_state_r == RD_RESP);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // readback selection; unmapped and reserved bits read as zero
  assign rd_byte = !rd_mapped ? BYTE_ZERO :
    (rd_idx == IDX_CNTL) ? cnt_r[7:0] :
    (rd_idx == IDX_CNTH) ? cnt_hi_hold_r :
    (rd_idx == IDX_CTL) ? {flag_r, ctl_cfg_r} :
    (rd_idx == IDX_OVFM) ? {7'h00, ovf_mask_r} :
    (rd_idx == IDX_CCTL0) ? cctl_r[0] :
    (rd_idx == IDX_CCTL0 + 8'h01) ? cctl_r[1] :
    (rd_idx == IDX_CCTL2) ? cctl_r[2] :
    (rd_idx == IDX_CC0L) ? ch_val[0][7:0] :
    (rd_idx == IDX_CC0H) ? ch_val[0][15:8] :
    (rd_idx == IDX_CC1L) ? ch_val[1][7:0] :
    (rd_idx == IDX_CC1H) ? ch_val[1][15:8] :
    (rd_idx == IDX_CC2L) ? ch_val[2][7:0] : ch_val[2][15:8];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= RD_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      case (rd_state_r)
        RD_IDLE: begin
          if (rd_fire) begin
            rd_state_r <= RD_RESP;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_r <= RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= RD_IDLE;
        end
      endcase
    end
  end

  // mode and prescaler come straight from the control register
  assign mode = tcp_mode_t'(ctl_cfg_r[CTL_MODE_LSB +: 2]);
  assign run = (mode != TCP_SUSPEND);
  assign updown = (mode == TCP_UPDOWN);
  // a counter clear in the same cycle beats a step, so its events never fire
  assign adv = step && !wr_cntl;
  assign cc0 = ch_val[0];
  assign at_zero = adv && (cnt_nxt == CNT_ZERO);

  tcp_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .global_tick(global_tick),
    .run(run),
    .div_sel(ctl_cfg_r[CTL_DIV_LSB +: 2]),
    .step(step)
  );

  // next count per counting mode
  always_comb begin
    cnt_nxt = cnt_r;
    dir_down_nxt = dir_down_r;
    moving_down = 1'b0;
    case (mode)
      TCP_FREE: begin
        cnt_nxt = cnt_r + CNT_ONE; // wraps 0xFFFF to 0x0000
        dir_down_nxt = 1'b0;
      end
      TCP_MODULO: begin
        cnt_nxt = (cnt_r == cc0) ? CNT_ZERO : cnt_r + CNT_ONE;
        dir_down_nxt = 1'b0;
      end
      TCP_UPDOWN: begin
        // turn at cc0 and at zero; a full cycle spans 2 * cc0 steps
        moving_down = dir_down_r ? (cnt_r != CNT_ZERO) : (cnt_r >= cc0);
        cnt_nxt = moving_down ? cnt_r - CNT_ONE : cnt_r + CNT_ONE;
        dir_down_nxt = moving_down ? (cnt_nxt != CNT_ZERO) : (cnt_nxt >= cc0);
      end
      default: begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  // counter and low-byte-read latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= CNT_ZERO;
      dir_down_r <= 1'b0;
      cnt_hi_hold_r <= BYTE_ZERO;
    end else begin
      if (wr_cntl) begin
        cnt_r <= CNT_ZERO;
        dir_down_r <= 1'b0;
      end else if (step) begin
        cnt_r <= cnt_nxt;
        dir_down_r <= dir_down_nxt;
      end
      if (rd_cntl) begin
        cnt_hi_hold_r <= cnt_r[15:8];
      end
    end
  end

  // terminal count: 0xFFFF free, cc0 modulo, zero in up/down
  assign ovf_evt = adv && (((mode == TCP_FREE) && (cnt_nxt == CNT_MAX)) ||
                           ((mode == TCP_MODULO) && (cnt_nxt == cc0)) ||
                           (updown && (cnt_nxt == CNT_ZERO)));
  // flag order is {ch2, ch1, ch0, ovf} at control bits 7..4
  assign flag_set = {ch_match[2], ch_match[1],
                     updown ? (at_zero && ch_en[0]) : ch_match[0],
                     ovf_evt};
  assign flag_clr = wr_ctl ? ~wbyte_r[7:CTL_OVF_BIT] : 4'h0;
  // set wins over a clear in the same cycle so no event is lost
  assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= FLAG_RST;
      ctl_cfg_r <= CTL_CFG_RST;
      ovf_mask_r <= OVFM_RST;
      dma_r <= 3'h0;
    end else begin
      flag_r <= flag_nxt;
      dma_r <= ch_match;
      if (wr_ctl) begin
        ctl_cfg_r <= wbyte_r[3:0];
      end
      if (wr_ovfm) begin
        ovf_mask_r <= wbyte_r[0];
      end
    end
  end

  // one level request; it stays high until software clears the flag
  // and rises at once when a mask is set over a pending flag
  assign irq_req = |(flag_r[3:1] & ch_im) | (flag_r[0] & ovf_mask_r);
  assign dma_trigger_channel0 = dma_r[0];
  assign dma_trigger_channel1 = dma_r[1];
  assign dma_trigger_channel2 = dma_r[2];
  assign ch_out = ch_pin;
  assign ch_oe = ch_en;

  // per-channel control register, decode and compare logic
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      localparam logic [7:0] IDX_L = IDX_CC0L + IDX_CC_STEP * 8'(gi);
      localparam logic [7:0] IDX_C = IDX_CCTL0 + 8'(gi);
      assign ch_wr_low[gi] = wr_en8 && (wr_idx == IDX_L);
      assign ch_wr_high[gi] = wr_en8 && (wr_idx == IDX_L + 8'h01);
      assign ch_wr_cctl[gi] = wr_en8 && (wr_idx == IDX_C);
      assign ch_en[gi] = cctl_r[gi][CCTL_EN_BIT];
      assign ch_im[gi] = cctl_r[gi][CCTL_IM_BIT];

      // bit 7 reserved and kept at zero
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cctl_r[gi] <= CCTL_RST;
        end else if (ch_wr_cctl[gi]) begin
          cctl_r[gi] <= wbyte_r & CCTL_WMASK;
        end
      end

      tcp_channel #(
        .IS_CH0(gi == 0)
      ) u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .adv(adv),
        .cnt_nxt(cnt_nxt),
        .moving_down(moving_down),
        .updown(updown),
        .ch0_match(adv && (cnt_nxt == cc0)),
        .en(ch_en[gi]),
        .cmp_mode(cctl_r[gi][CCTL_CMP_LSB +: 3]),
        .wr_low(ch_wr_low[gi]),
        .wr_high(ch_wr_high[gi]),
        .wbyte(wbyte_r),
        .match(ch_match[gi]),
        .pin(ch_pin[gi]),
        .value(ch_val[gi])
      );
    end
  endgenerate
endmodule

// ===== dv/tcp_pin_load.sv
// far side of the channel pins: one external pull-down on each pad
// assumes ch_oe is high while the timer drives a pin
`timescale 1ns/1ps
module tcp_pin_load (
  input wire logic [2:0] ch_out,
  input wire logic [2:0] ch_oe,
  output logic [2:0] pad
);
  // an undriven pad falls to the pull-down level, never keeps the last value
  assign pad = ch_out & ch_oe;
endmodule

// ===== dv/tcp_timer_chk.sv
// checker: bus handshakes, reset state and trigger timing of the timer top
// bound below to every tcp_timer instance, sees its ports only
`timescale 1ns/1ps
module tcp_timer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic global_tick,
  input wire logic [2:0] ch_oe,
  input wire logic dma_trigger_channel1,
  input wire logic irq_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until the master takes them
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp moved early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved early");
  // no new request while an answer is pending
  property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wblk: assert property (p_wblk) else $error("write taken early");
  property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rblk: assert property (p_rblk) else $error("read taken early");
  // answer latency fixed by the bus logic
  property p_bdly;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_bdly: assert property (p_bdly) else $error("write answer late");
  property p_rdly; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rdly: assert property (p_rdly) else $error("read answer late");
  // pins undriven and quiet after reset
  property p_rst;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && ch_oe == 3'h0 && !irq_req;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // a channel 1 trigger only follows a global tick one or two cycles back
  property p_dma;
    dma_trigger_channel1 |-> $past(global_tick) || $past(global_tick, 2);
  endproperty
  a_dma: assert property (p_dma) else $error("trigger without tick");
  c_dma: cover property (dma_trigger_channel1);
  c_irq: cover property ($rose(irq_req));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind tcp_timer tcp_timer_chk tcp_timer_chk_inst (.*);

// ===== dv/timer16_compare_pwm_tb.sv
// self-checking bench for the compare/pwm timer over axi4-lite
// assumes tcp_pkg indices, byte address four times the index
`timescale 1ns/1ps
module timer16_compare_pwm_tb;
  import tcp_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic wr;
    logic [7:0] wd;
    logic [7:0] ex;
    logic [1:0] rs;
  } tcp_row_t;
  localparam logic [7:0] cctl1_idx = IDX_CCTL0 + 8'h01;
  logic aclk, aresetn, global_tick, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq_req;
  logic dma_trigger_channel0, dma_trigger_channel1, dma_trigger_channel2;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot, ch_out, ch_oe, pad, pin0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] rdat;
  int err_count, n_checks, i, k;
  tcp_row_t rows [5];
  tcp_timer tcp_timer_inst (.*);
  tcp_pin_load tcp_pin_load_inst (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a wait that ran out ends the run at once
  task automatic lost;
    err_count++;
    $display("CHECK FAILED t=%0t no answer", $time);
    close_out();
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic a, w;
    int n;
    a = 0;
    w = 0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid) break;
      if (!a && s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (n == 100) lost();
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input logic ck = 1'b1,
                    input logic [1:0] er = RESP_OKAY);
    logic a;
    int n;
    a = 0;
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid) break;
      if (!a && s_axi_arready) begin
        a = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    if (n == 100) lost();
    rdat = s_axi_rdata[7:0];
    chk(s_axi_rresp, er);
    if (ck) chk(rdat, ex);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // channel 1 trigger, bounded wait
  task automatic wdma;
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if (dma_trigger_channel1) break;
    end
    if (n == 2000) lost();
  endtask
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    aresetn = 0;
    global_tick = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'h1;
    rows = '{'{IDX_CTL, 1'b0, 8'h00, 8'h00, RESP_OKAY}, '{IDX_CCTL0, 1'b0, 8'h00, 8'h40, RESP_OKAY},
             '{IDX_CNTH, 1'b0, 8'h00, 8'h00, RESP_OKAY}, '{IDX_CCTL2, 1'b1, 8'hFB, 8'h7B, RESP_OKAY},
             '{8'hE0, 1'b1, 8'h55, 8'h00, RESP_SLVERR}};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, reserved bit, unmapped index
    for (i = 0; i < 5; i++) begin
      if (rows[i].wr) wr(rows[i].idx, rows[i].wd, rows[i].rs);
      rd(rows[i].idx, rows[i].ex, 1'b1, rows[i].rs);
    end
    // set, clear, toggle at 0x0123; mask raised only after the match
    wr(IDX_CC1L, 8'h23);
    wr(IDX_CC1H, 8'h01);
    for (k = 0; k < 3; k++) begin
      wr(cctl1_idx, {2'b00, k[2:0], 3'b100});
      chk(ch_oe, 3'b010);
      wr(IDX_CNTL, 8'h00);
      wr(IDX_CTL, 8'h01);
      wdma();
      chk(irq_req, 1'b0);
      wr(cctl1_idx, {2'b01, k[2:0], 3'b100});
      chk(irq_req, 1'b1);
      rd(IDX_CTL, 8'h41);
      wr(IDX_CTL, 8'hB1);
      chk(irq_req, 1'b0);
      wr(IDX_CTL, 8'h00);
      chk(ch_out[1], !k[0]);
      chk(pad, {1'b0, ~k[0], 1'b0});
    end
    // stopped near 0x0130: pins hold, high byte stays latched
    pin0 = ch_out;
    rd(IDX_CNTL, 8'h00, 1'b0);
    repeat (20) @(posedge aclk);
    chk(ch_out, pin0);
    wr(IDX_CNTL, 8'hAA);
    rd(IDX_CNTH, 8'h01);
    rd(IDX_CNTL, 8'h00);
    rd(IDX_CNTH, 8'h00);
    // running with no tick must leave the counter alone
    global_tick <= 1'b0;
    wr(IDX_CTL, 8'h01);
    repeat (30) @(posedge aclk);
    rd(IDX_CNTL, 8'h00);
    wr(IDX_CTL, 8'h00);
    // code 100 defers the new value 0x0005 until the counter wraps
    wr(cctl1_idx, 8'h24);
    wr(IDX_CC1L, 8'h05);
    wr(IDX_CC1H, 8'h00);
    wr(IDX_CNTL, 8'h00);
    global_tick <= 1'b1;
    wr(IDX_CTL, 8'h01);
    k = 0;
    repeat (40) begin
      @(posedge aclk);
      if (dma_trigger_channel1) k = 1;
    end
    chk(k[0], 1'b0);
    wr(IDX_CTL, 8'h00);
    // edge pwm: modulo counting 0 to 0x0010, code 110 sets at period, clears on own match
    wr(IDX_CC0L, 8'h10);
    wr(IDX_CC0H, 8'h00);
    wr(cctl1_idx, 8'h34);
    wr(IDX_CNTL, 8'h00);
    wr(IDX_CTL, 8'h02);
    wdma();
    chk(ch_out[1], 1'b0);
    wr(IDX_CTL, 8'h00);
    close_out();
  end
endmodule
